// >>> fls_pkg.sv
// Package for the fiber link statistics block: register byte offsets, widths, timing.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
package fls_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned SEC_CYCLES = SECOND_S * CLK_HZ;
  localparam logic [15:0] SEC_PER_MIN = 16'h003c;
  localparam logic [15:0] PAGE_LEN_RST = 16'h0100;
  localparam logic [15:0] IDLE_WAIT_RST = 16'h0010;
  localparam logic [7:0] OFS_RX_DATA_WORD_L = 8'h00;
  localparam logic [7:0] OFS_RX_DATA_WORD_H = 8'h04;
  localparam logic [7:0] OFS_RX_CTRL_WORD_L = 8'h08;
  localparam logic [7:0] OFS_RX_CTRL_WORD_H = 8'h0c;
  localparam logic [7:0] OFS_TX_DATA_WORD_L = 8'h10;
  localparam logic [7:0] OFS_TX_DATA_WORD_H = 8'h14;
  localparam logic [7:0] OFS_TX_CTRL_WORD_L = 8'h18;
  localparam logic [7:0] OFS_TX_CTRL_WORD_H = 8'h1c;
  localparam logic [7:0] OFS_TX_DATA_PAGE_L = 8'h20;
  localparam logic [7:0] OFS_TX_DATA_PAGE_H = 8'h24;
  localparam logic [7:0] OFS_TX_CTRL_PAGE_L = 8'h28;
  localparam logic [7:0] OFS_TX_CTRL_PAGE_H = 8'h2c;
  localparam logic [7:0] OFS_TX_FULL_DATA_PAGE_L = 8'h30;
  localparam logic [7:0] OFS_TX_FULL_DATA_PAGE_H = 8'h34;
  localparam logic [7:0] OFS_TX_FULL_CTRL_PAGE_L = 8'h38;
  localparam logic [7:0] OFS_TX_FULL_CTRL_PAGE_H = 8'h3c;
  localparam logic [7:0] OFS_LINK_FULL_EVENTS = 8'h40;
  localparam logic [7:0] OFS_LINK_DOWN_EVENTS = 8'h44;
  localparam logic [7:0] OFS_UPTIME_MINUTES = 8'h48;
  localparam logic [7:0] OFS_UPTIME_SECONDS = 8'h4c;
  localparam logic [7:0] OFS_PAGE_LENGTH_INFO = 8'h50;
  localparam logic [7:0] OFS_IDLE_WAIT_INFO = 8'h54;
  localparam int unsigned NUM_CNT32 = 8;
  localparam int unsigned IDX_RXD = 0;
  localparam int unsigned IDX_RXC = 1;
  localparam int unsigned IDX_TXD = 2;
  localparam int unsigned IDX_TXC = 3;
  localparam int unsigned IDX_PGD = 4;
  localparam int unsigned IDX_PGC = 5;
  localparam int unsigned IDX_FPD = 6;
  localparam int unsigned IDX_FPC = 7;
endpackage

// >>> fls_counter.sv
// Saturation-free event counter of parameterised width.
// Assumes one-cycle increment pulses on the system clock.
`timescale 1ns/100ps
module fls_counter #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic inc,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  assign nxt_count = inc ? count_ff + WIDTH'(1) : count_ff;
  assign count = count_ff;
  always_ff @(posedge mclk) begin
    if (srst) count_ff <= '0;
    else count_ff <= nxt_count;
  end
endmodule // fls_counter

// >>> fls_uptime.sv
// Uptime clock: seconds within the current minute and minutes since reset.
// Assumes the system clock rate given in the package; tick count is a parameter.
`timescale 1ns/100ps
module fls_uptime #(
  parameter int unsigned SEC_CYCLES = fls_pkg::SEC_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  output logic [15:0] minutes,
  output logic [15:0] seconds
);
  logic [31:0] tick_ff;
  logic [15:0] sec_ff;
  logic [15:0] min_ff;
  wire sec_tick = (tick_ff == 32'(SEC_CYCLES - 1));
  wire min_tick = sec_tick && (sec_ff == fls_pkg::SEC_PER_MIN - 16'h0001);
  assign minutes = min_ff;
  assign seconds = sec_ff;
  always_ff @(posedge mclk) begin
    if (srst || sec_tick) tick_ff <= '0;
    else tick_ff <= tick_ff + 32'h0000_0001;
  end
  always_ff @(posedge mclk) begin
    if (srst || min_tick) sec_ff <= '0;
    else if (sec_tick) sec_ff <= sec_ff + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (srst) min_ff <= '0;
    else if (min_tick) min_ff <= min_ff + 16'h0001;
  end
endmodule // fls_uptime

// >>> fls_stats.sv
// Fiber link statistics top: traffic counters, page packing tracker, uptime, AHB-Lite regs.
// Assumes link strobes are one-cycle, synchronous to mclk; one AHB-Lite master.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module fls_stats #(
  parameter int unsigned SEC_CYCLES = fls_pkg::SEC_CYCLES,
  parameter logic [15:0] PAGE_LEN = fls_pkg::PAGE_LEN_RST,
  parameter logic [15:0] IDLE_WAIT = fls_pkg::IDLE_WAIT_RST
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_word_valid,
  input wire logic rx_word_is_ctrl,
  input wire logic tx_word_valid,
  input wire logic tx_word_is_ctrl,
  input wire logic link_full,
  input wire logic link_down,
  input wire logic cfg_load,
  input wire logic [15:0] cfg_page_len,
  input wire logic [15:0] cfg_idle_wait,
  output logic page_open,
  output logic page_is_ctrl,
  output logic page_close
);

  // One-hot page states; the default branch recovers an illegal code
  typedef enum logic [1:0] {
    FLS_PG_IDLE = 2'b01,
    FLS_PG_OPEN = 2'b10
  } fls_page_state_t;

  fls_page_state_t state_ff;
  fls_page_state_t nxt_state;
  logic [15:0] page_len_ff;
  logic [15:0] idle_wait_ff;
  logic [15:0] fill_ff;
  logic [15:0] nxt_fill;
  logic [15:0] idle_ff;
  logic [15:0] nxt_idle;
  logic type_ff;
  logic nxt_type;
  logic close_ff;
  logic lff_d_ff;
  logic ldn_d_ff;
  logic rd_pend_ff;
  logic [7:0] rd_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;
  localparam int unsigned NUM_CNT32_W = fls_pkg::NUM_CNT32;

  logic [NUM_CNT32_W-1:0] inc32;
  logic [31:0] cnt32 [fls_pkg::NUM_CNT32];
  logic [15:0] lff_cnt;
  logic [15:0] ldn_cnt;
  logic [15:0] up_min;
  logic [15:0] up_sec;

  // Configuration is loaded by the link's own setup path, never by the bus
  // A load while a page is open takes effect on the next word; the open
  // page is judged against the new length from then on.
  always_ff @(posedge mclk) begin
    if (srst) begin
      page_len_ff <= PAGE_LEN;
      idle_wait_ff <= IDLE_WAIT;
    end else if (cfg_load) begin
      page_len_ff <= cfg_page_len;
      idle_wait_ff <= cfg_idle_wait;
    end
  end

  // Page tracking; a zero page length is treated as one to avoid a stuck page
  wire [15:0] eff_len = (page_len_ff == 16'h0000) ? 16'h0001 : page_len_ff;
  wire type_change = tx_word_valid && (tx_word_is_ctrl != type_ff);
  wire idle_done = !tx_word_valid && (idle_ff >= idle_wait_ff);
  wire len_done = tx_word_valid && !type_change && (fill_ff + 16'h0001 == eff_len);
  wire is_open = (state_ff == FLS_PG_OPEN);
  wire close_now = is_open && (type_change || idle_done || len_done);
  wire close_full = is_open && len_done;
  wire closed_ctrl = type_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_fill = fill_ff;
    nxt_idle = idle_ff;
    nxt_type = type_ff;
    case (state_ff)
      FLS_PG_IDLE: begin
        if (tx_word_valid) begin
          nxt_type = tx_word_is_ctrl;
          nxt_idle = 16'h0000;
          if (eff_len == 16'h0001) begin
            nxt_state = FLS_PG_IDLE;
            nxt_fill = 16'h0000;
          end else begin
            nxt_state = FLS_PG_OPEN;
            nxt_fill = 16'h0001;
          end
        end
      end
      FLS_PG_OPEN: begin
        if (type_change) begin
          // Word of the other type starts a fresh page
          nxt_type = tx_word_is_ctrl;
          nxt_fill = 16'h0001;
          nxt_idle = 16'h0000;
          nxt_state = (eff_len == 16'h0001) ? FLS_PG_IDLE : FLS_PG_OPEN;
        end else if (len_done || idle_done) begin
          nxt_state = FLS_PG_IDLE;
          nxt_fill = 16'h0000;
          nxt_idle = 16'h0000;
        end else if (tx_word_valid) begin
          nxt_fill = fill_ff + 16'h0001;
          nxt_idle = 16'h0000;
        end else begin
          nxt_idle = idle_ff + 16'h0001;
        end
      end
      default: begin
        nxt_state = FLS_PG_IDLE;
        nxt_fill = 16'h0000;
        nxt_idle = 16'h0000;
      end
    endcase
  end

  // A one-word page length closes a page on the very word that opens it
  wire single_close = (eff_len == 16'h0001) && tx_word_valid && (!is_open || type_change);
  wire pg_event = close_now || single_close;
  // Page counts are steered by the closing page's type; a one-word page
  // uses the type of the word that both opens and closes it.
  // A complete page is counted both as a page and as a complete page,
  // so the complete counts can never run ahead of the page counts.
  // A type change and a one-word close in the same cycle each count a page
  wire dbl = close_now && single_close;

  // Page state, fill and idle counters share one reset so they agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= FLS_PG_IDLE;
      fill_ff <= '0;
      idle_ff <= '0;
      type_ff <= 1'b0;
      close_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      fill_ff <= nxt_fill;
      idle_ff <= nxt_idle;
      type_ff <= nxt_type;
      close_ff <= pg_event;
    end
  end

  // Both link levels are sampled once so an edge is seen exactly once;
  // a level held high counts a single event however long it lasts.
  // link full and link down edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      lff_d_ff <= 1'b0;
      ldn_d_ff <= 1'b0;
    end else begin
      lff_d_ff <= link_full;
      ldn_d_ff <= link_down;
    end
  end
  wire lff_rise = link_full && !lff_d_ff;
  wire ldn_rise = link_down && !ldn_d_ff;

  // Word counters step on every valid strobe; one word per cycle at most,
  // so a one-bit increment can never lose an event.
  // classify by type
  assign inc32[fls_pkg::IDX_RXD] = rx_word_valid && !rx_word_is_ctrl;
  assign inc32[fls_pkg::IDX_RXC] = rx_word_valid && rx_word_is_ctrl;
  assign inc32[fls_pkg::IDX_TXD] = tx_word_valid && !tx_word_is_ctrl;
  assign inc32[fls_pkg::IDX_TXC] = tx_word_valid && tx_word_is_ctrl;
  assign inc32[fls_pkg::IDX_PGD] = (close_now && !closed_ctrl) ||
                                   (single_close && !tx_word_is_ctrl && !dbl) ||
                                   (dbl && !tx_word_is_ctrl && closed_ctrl);
  assign inc32[fls_pkg::IDX_PGC] = (close_now && closed_ctrl) ||
                                   (single_close && tx_word_is_ctrl && !dbl) ||
                                   (dbl && tx_word_is_ctrl && !closed_ctrl);
  assign inc32[fls_pkg::IDX_FPD] = (close_full && !closed_ctrl) ||
                                   (single_close && !tx_word_is_ctrl);
  assign inc32[fls_pkg::IDX_FPC] = (close_full && closed_ctrl) ||
                                   (single_close && tx_word_is_ctrl);

  // One counter per 32-bit statistic, indexed as in the package
  // counters from zero
  genvar gi;
  generate
    for (gi = 0; gi < fls_pkg::NUM_CNT32; gi++) begin : g_cnt32
      fls_counter #(.WIDTH(32)) u_cnt (
        .mclk(mclk),
        .srst(srst),
        .inc(inc32[gi]),
        .count(cnt32[gi])
      );
    end
  endgenerate

  fls_counter #(.WIDTH(16)) u_lff (
    .mclk(mclk),
    .srst(srst),
    .inc(lff_rise),
    .count(lff_cnt)
  );

  fls_counter #(.WIDTH(16)) u_ldn (
    .mclk(mclk),
    .srst(srst),
    .inc(ldn_rise),
    .count(ldn_cnt)
  );

  // The uptime keeps running across link activity and is never cleared
  // by the bus; only the board reset restarts it.
  // uptime source
  fls_uptime #(.SEC_CYCLES(SEC_CYCLES)) u_up (
    .mclk(mclk),
    .srst(srst),
    .minutes(up_min),
    .seconds(up_sec)
  );

  // Only haddr[7:0] is decoded, so the map aliases every 256 bytes.
  // hsize and hwdata are not used: every register is read-only.
  // Bus: reads answer in the data phase after one wait state; writes are ignored
  wire take = hsel && hready && htrans[1];
  wire take_rd = take && !hwrite;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
    end else begin
      rd_pend_ff <= take_rd;
      rd_addr_ff <= haddr[7:0];
    end
  end

  // Data is captured one cycle early so hrdata comes straight from a flop;
  // the cost is a one-cycle wait state on every read.
  // low and high halves
  always_comb begin
    case (rd_addr_ff)
      fls_pkg::OFS_RX_DATA_WORD_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_RXD][15:0]};
      fls_pkg::OFS_RX_DATA_WORD_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_RXD][31:16]};
      fls_pkg::OFS_RX_CTRL_WORD_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_RXC][15:0]};
      fls_pkg::OFS_RX_CTRL_WORD_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_RXC][31:16]};
      fls_pkg::OFS_TX_DATA_WORD_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_TXD][15:0]};
      fls_pkg::OFS_TX_DATA_WORD_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_TXD][31:16]};
      fls_pkg::OFS_TX_CTRL_WORD_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_TXC][15:0]};
      fls_pkg::OFS_TX_CTRL_WORD_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_TXC][31:16]};
      fls_pkg::OFS_TX_DATA_PAGE_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_PGD][15:0]};
      fls_pkg::OFS_TX_DATA_PAGE_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_PGD][31:16]};
      fls_pkg::OFS_TX_CTRL_PAGE_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_PGC][15:0]};
      fls_pkg::OFS_TX_CTRL_PAGE_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_PGC][31:16]};
      fls_pkg::OFS_TX_FULL_DATA_PAGE_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_FPD][15:0]};
      fls_pkg::OFS_TX_FULL_DATA_PAGE_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_FPD][31:16]};
      fls_pkg::OFS_TX_FULL_CTRL_PAGE_L: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_FPC][15:0]};
      fls_pkg::OFS_TX_FULL_CTRL_PAGE_H: rd_mux = {16'h0000, cnt32[fls_pkg::IDX_FPC][31:16]};
      fls_pkg::OFS_LINK_FULL_EVENTS: rd_mux = {16'h0000, lff_cnt};
      fls_pkg::OFS_LINK_DOWN_EVENTS: rd_mux = {16'h0000, ldn_cnt};
      fls_pkg::OFS_UPTIME_MINUTES: rd_mux = {16'h0000, up_min};
      fls_pkg::OFS_UPTIME_SECONDS: rd_mux = {16'h0000, up_sec};
      fls_pkg::OFS_PAGE_LENGTH_INFO: rd_mux = {16'h0000, page_len_ff};
      fls_pkg::OFS_IDLE_WAIT_INFO: rd_mux = {16'h0000, idle_wait_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // hreadyout drops only for the cycle after a read is taken, so a write
  // never waits.
  // Read answers in the second data-phase cycle
  wire rd_wait = take_rd;
  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata_ff <= 32'h0000_0000;
      hreadyout <= 1'b1;
    end else begin
      hrdata_ff <= rd_pend_ff ? rd_mux : 32'h0000_0000;
      hreadyout <= !rd_wait;
    end
  end
  assign hrdata = hrdata_ff;

  // No error response exists: every access completes with OKAY
  always_ff @(posedge mclk) begin
    if (srst) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // Page status mirrors the next state so it lines up with page_close
  always_ff @(posedge mclk) begin
    if (srst) begin
      page_open <= 1'b0;
      page_is_ctrl <= 1'b0;
    end else begin
      page_open <= (nxt_state == FLS_PG_OPEN);
      page_is_ctrl <= nxt_type;
    end
  end
  assign page_close = close_ff;

endmodule // fls_stats

// >>> fls_stats_chk.sv
// Checker for fls_stats: bus answer timing and page tracker relations.
// Assumes one AHB-Lite master with hready fed back from hreadyout.
`timescale 1ns/100ps
module fls_stats_chk #(
  parameter logic [15:0] IDLE_WAIT = 16'h0010
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_word_valid,
  input wire logic tx_word_is_ctrl,
  input wire logic page_open,
  input wire logic page_is_ctrl,
  input wire logic page_close
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic [16:0] idle_ff;
  wire logic go = hsel & hready & htrans[1];
  wire logic swap = tx_word_valid & page_open & (tx_word_is_ctrl ^ page_is_ctrl);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // Saturates so a stuck page cannot wrap back under the bound
  always_ff @(posedge mclk) begin
    if (srst || !page_open || tx_word_valid)
      idle_ff <= 17'h0_0000;
    else if (idle_ff != 17'h1_ffff)
      idle_ff <= idle_ff + 17'h0_0001;
  end
  AST_RD_WAIT: assert property (go && !hwrite |=> s_rd_wait)
    else $error("read answer timing wrong");
  AST_RD_IDLE: assert property ($past(hreadyout) |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_WR: assert property (go && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_TYPE: assert property (tx_word_valid |=> page_is_ctrl == $past(tx_word_is_ctrl))
    else $error("page type wrong");
  AST_OPEN: assert property ($rose(page_open) |-> $past(tx_word_valid))
    else $error("page opened without word");
  AST_SWAP: assert property (swap |-> ##[1:2] page_close)
    else $error("type change did not close page");
  AST_IDLE: assert property (idle_ff <= {1'b0, IDLE_WAIT} + 17'h0_0003)
    else $error("idle page left open");
  AST_RST: assert property ($fell(srst) |-> hreadyout && !page_open && !page_close)
    else $error("bad state after reset");
endmodule // fls_stats_chk

bind fls_stats fls_stats_chk #(.IDLE_WAIT(IDLE_WAIT)) u_chk (
  .mclk(mclk), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_word_valid(tx_word_valid),
  .tx_word_is_ctrl(tx_word_is_ctrl), .page_open(page_open), .page_is_ctrl(page_is_ctrl),
  .page_close(page_close)
);

// >>> fls_link_model.sv
// Link-side model: puts the bench's per-cycle requests on the link strobes and levels.
// Assumes one request per clock: rx valid, rx type, tx valid, tx type, full, down.
`timescale 1ns/100ps
module fls_link_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [5:0] req,
  output logic [5:0] link
);
  // word types and levels
  // Type bits keep the requested value while valid is low, not a kind constant
  always_ff @(posedge mclk) begin
    if (srst)
      link <= 6'h00;
    else
      link <= req;
  end
endmodule // fls_link_model

// >>> tb.sv
// Self-checking bench for fls_stats: register reads, random link traffic, uptime, reset.
// Assumes the link model drives the link pins and the checker is bound into fls_stats.
`timescale 1ns/100ps
module tb;
  localparam int unsigned SECC = 32'h0000_000a;
  localparam int unsigned MINC = SECC * fls_pkg::SEC_PER_MIN;
  localparam logic [15:0] IW = 16'h0005;
  logic mclk, srst, hsel, hwrite, cfg_load, hreadyout, hresp, popen, pctrl, pclose, op, ty, lf, ld;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] cfg_page_len, cfg_idle_wait, pl, iw;
  logic [5:0] req;
  wire logic rxv, rxc, txv, txc, lfull, ldown;
  int seed = 32'h0000_46cb;
  int err_count = 0, comparisons = 0, cyc = 0, fl = 0;
  int unsigned cnt [10];
  fls_stats #(.SEC_CYCLES(SECC), .IDLE_WAIT(IW)) uut (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_word_valid(rxv), .rx_word_is_ctrl(rxc), .tx_word_valid(txv),
    .tx_word_is_ctrl(txc), .link_full(lfull), .link_down(ldown), .cfg_load(cfg_load),
    .cfg_page_len(cfg_page_len), .cfg_idle_wait(cfg_idle_wait), .page_open(popen),
    .page_is_ctrl(pctrl), .page_close(pclose)
  );
  fls_link_model u_link (.mclk(mclk), .srst(srst), .req(req), .link({rxv, rxc, txv, txc, lfull, ldown}));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= srst ? 0 : cyc + 1;
  task automatic final_report();
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 40);
    if (hreadyout !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= $random(seed);
    wait_rdy();
    d = hrdata;
  endtask
  function automatic logic [31:0] exp_reg(input int i);
    if (i < 16)
      return i % 2 ? cnt[i / 2] >> 16 : cnt[i / 2] & 32'h0000_ffff;
    if (i < 18)
      return cnt[i - 8] & 32'h0000_ffff;
    if (i == 20 || i == 21)
      return {16'h0000, i == 20 ? pl : iw};
    return 32'h0000_0000;
  endfunction
  function automatic void step(input logic [5:0] r);
    cnt[r[4]] += r[5];
    cnt[8] += r[1] & !lf;
    cnt[9] += r[0] & !ld;
    lf = r[1];
    ld = r[0];
    if (op && (!r[3] || ty != r[2])) begin
      cnt[4 + ty]++;
      op = 1'b0;
    end
    if (r[3]) begin
      ty = r[2];
      fl = op ? fl + 1 : 1;
      op = 1'b1;
      cnt[2 + ty]++;
      if (fl == pl) begin
        cnt[4 + ty]++;
        cnt[6 + ty]++;
        op = 1'b0;
      end
    end
  endfunction
  task automatic check_all();
    logic [31:0] d;
    for (int i = 0; i < 24; i++) begin
      if (i != 18 && i != 19) begin
        bus(8'(i * 4), 1'b0, d);
        check(d, exp_reg(i));
      end
    end
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    req <= 6'h00;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    cnt = '{default: 0};
    {op, lf, ld} = 3'b000;
    pl = fls_pkg::PAGE_LEN_RST;
    iw = IW;
    @(posedge mclk);
  endtask
  // Gaps are zero or far above the idle limit, so the model needs no exact close cycle
  task automatic traffic(input int n);
    logic [31:0] x;
    logic [5:0] r;
    logic tr;
    int g;
    tr = 1'b0;
    g = 0;
    for (int k = 0; k < n + 30; k++) begin
      x = $random(seed);
      if (x[9:6] == 4'h0)
        g = 20;
      if (x[5:3] == 3'h0)
        tr = ~tr;
      r = k < n ? {x[0], x[1], g == 0, tr, x[2], x[3]} : 6'h00;
      if (g > 0)
        g--;
      @(posedge mclk);
      req <= r;
      step(r);
    end
  endtask
  initial begin
    logic [31:0] d;
    {srst, hsel, hwrite, cfg_load} = 4'h8;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    req = 6'h00;
    cfg_page_len = 16'h0000;
    cfg_idle_wait = 16'h0000;
    @(posedge mclk);
    do_reset();
    check_all();
    cfg_load <= 1'b1;
    cfg_page_len <= 16'h0004;
    cfg_idle_wait <= IW;
    @(posedge mclk);
    cfg_load <= 1'b0;
    pl = 16'h0004;
    traffic(1500);
    bus(fls_pkg::OFS_TX_DATA_WORD_L, 1'b1, d);
    bus(fls_pkg::OFS_PAGE_LENGTH_INFO, 1'b1, d);
    bus(fls_pkg::OFS_UPTIME_MINUTES, 1'b1, d);
    check_all();
    bus(fls_pkg::OFS_UPTIME_MINUTES, 1'b0, d);
    check({31'h0000_0000, d * MINC <= cyc && cyc < d * MINC + MINC + 5}, 32'h0000_0001);
    bus(fls_pkg::OFS_UPTIME_SECONDS, 1'b0, d);
    check({31'h0000_0000, d < fls_pkg::SEC_PER_MIN}, 32'h0000_0001);
    traffic(200);
    do_reset();
    check_all();
    final_report();
  end
endmodule // tb
